// >>> shared/gsre_consts.vh
/*
 constants for the send/receive transfer engine: status bit positions,
 selector fields, default terminator characters and timing counts.
 assumes inclusion by bare name from the verilog/ design files.
*/
`ifndef GSRE_CONSTS_VH
`define GSRE_CONSTS_VH

// ========================================
// status bit positions
`define GSRE_ST_EOT_BIT 5
`define GSRE_ST_TMO_BIT 3
`define GSRE_ST_NLS_BIT 1
`define GSRE_ST_NCT_BIT 1
`define GSRE_ST_ADR_BIT 0

// ========================================
// field positions
`define GSRE_ADR_SEL_HI 7
`define GSRE_ADR_SEL_LO 6
`define GSRE_ADR_ZERO_BIT 5
`define GSRE_TRM_ENA_BIT 2
`define GSRE_MAX_ADDR 5'h1E

// ========================================
// bus command bytes
`define GSRE_CMD_UNL 8'h3F
`define GSRE_CMD_LAG 8'h20
`define GSRE_CMD_TAG 8'h40

// ========================================
// default terminator characters
`define GSRE_CH_LF 8'h0A
`define GSRE_CH_CR 8'h0D
`define GSRE_CH_COMMA 8'h2C
`define GSRE_CH_SEMI 8'h3B

// ========================================
// timing
`define GSRE_CLK_NS 10
`define GSRE_TMO_US 10000
`define GSRE_TMO_CYC ((`GSRE_TMO_US * 1000) / `GSRE_CLK_NS)

`endif

// >>> sim/gsre_monitor.sv
/*
 port checker for gsre_engine, attached by bind.
 assumes the engine's ports only, mclk domain, nrst low = reset.
*/
`timescale 1ns/1ps
`default_nettype none
module gsre_monitor (
	// clock and reset
	input wire mclk,
	input wire nrst,
	// host side
	input wire board_active,
	input wire is_listener,
	input wire is_controller,
	input wire array_receive_call,
	input wire [15:0] rcv_max_len,
	input wire send_call,
	input wire [7:0] send_addr,
	// completion
	input wire busy,
	input wire done,
	input wire [7:0] status,
	// bus drive enables
	input wire [7:0] dio_oe_n,
	input wire dav_oe_n,
	input wire atn_oe_n
);
	// ========================================
	// checks
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);
	wire take_rx = !busy && board_active && array_receive_call;
	wire take_tx = !busy && board_active && send_call && !array_receive_call;
	wire bad_adr = send_addr[5] || send_addr[4:0] > 5'h1E;
	a_rx_not_listener: assert property (take_rx && !is_listener |-> ##2 done && status == 8'h02)
		else $error("listener flag missing");
	a_rx_zero_len: assert property (take_rx && is_listener && rcv_max_len == 16'h0000 |-> ##[1:4] done && status == 8'h00)
		else $error("zero length receive");
	a_tx_not_ctrl: assert property (take_tx && !is_controller |-> ##2 done && status[1])
		else $error("controller flag missing");
	a_tx_bad_addr: assert property (take_tx && is_controller && bad_adr |-> ##2 done && status[0])
		else $error("address flag missing");
	a_status_spare_zero: assert property (done |-> (status & 8'hD4) == 8'h00)
		else $error("spare status bit set");
	a_done_one_cycle: assert property (done |=> !done)
		else $error("done longer than a cycle");
	a_status_holds: assert property (!busy && !done && !send_call && !array_receive_call |=> $stable(status))
		else $error("status moved while idle");
	a_bus_idle_free: assert property (!busy [*2] |-> &dio_oe_n && dav_oe_n && atn_oe_n)
		else $error("bus driven while idle");
endmodule // gsre_monitor
bind gsre_engine gsre_monitor i_gsre_monitor (.*);
`default_nettype wire

// >>> sim/gsre_peer.sv
/*
 bus instrument: listener capturing bytes, or talker sending queued bytes.
 assumes lines resolve as OR of drives, idle low, high = asserted.
*/
`timescale 1ns/1ps
`default_nettype none
module gsre_peer (
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// bench control
	input wire logic talk_en,
	input wire logic stall,
	input wire logic [3:0] slow,
	// resolved lines
	input wire logic [7:0] dio,
	input wire logic dav,
	input wire logic nrfd,
	input wire logic ndac,
	input wire logic atn,
	input wire logic eoi,
	// own drive, zero when released
	output logic [7:0] dio_o,
	output logic dav_o,
	output logic nrfd_o,
	output logic ndac_o,
	output logic eoi_o
);
	// ========================================
	// handshake
	logic [8:0] txq[$];
	logic [9:0] rxq[$];
	logic [3:0] w;
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			{dio_o, dav_o, nrfd_o, ndac_o, eoi_o, w} <= '0;
		else if (w != 4'h0)
			w <= w - 4'h1;
		else if (!talk_en)
		begin
			{dio_o, dav_o, eoi_o} <= '0;
			if (dav && ndac_o)
			begin
				rxq.push_back({atn, eoi, dio});
				ndac_o <= 1'b0;
				nrfd_o <= 1'b1;
				w <= slow;
			end
			else if (!dav)
			begin
				ndac_o <= 1'b1;
				nrfd_o <= stall;
			end
		end
		else
		begin
			{nrfd_o, ndac_o} <= '0;
			if (dav_o && !ndac)
			begin
				{dio_o, dav_o, eoi_o} <= '0;
				void'(txq.pop_front());
				w <= slow;
			end
			else if (!dav_o && txq.size() > 0 && !nrfd && ndac && !ndac_o)
			begin
				{eoi_o, dio_o} <= txq[0];
				dav_o <= 1'b1;
			end
		end
	end
endmodule // gsre_peer
`default_nettype wire

// >>> sim/tb_top.sv
/*
 self-checking bench for gsre_engine with the instrument peer.
 assumes lines resolve as OR of drives, idle low.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	// ========================================
	// signals
	logic mclk = 0;
	logic nrst = 0;
	logic [1:0] board_number, board_select_id, cfg_len;
	logic [2:0] cfg_index;
	logic [3:0] slow;
	logic [7:0] rcv_term, rx_data, send_addr, tx_char_in, status, dio_in, dio_out, dio_oe_n, p_dio;
	logic [15:0] rcv_max_len, cfg_chars, xfer_count, trm[4];
	logic [31:0] in_term_chars;
	logic board_select_strobe, board_active, is_listener, is_controller, array_receive_call, rx_valid, rx_ready;
	logic send_call, tx_char_valid, tx_char_ready, tx_char_last, send_terminator_config_call, busy, done;
	logic dav_in, dav_out, dav_oe_n, nrfd_in, nrfd_out, nrfd_oe_n, ndac_in, ndac_out, ndac_oe_n;
	logic eoi_in, eoi_out, eoi_oe_n, atn_out, atn_oe_n, p_dav, p_nrfd, p_ndac, p_eoi, talk_en, stall;
	logic [9:0] exp_q[$];
	int err_total = 0;
	int check_count = 0;
	always #5 mclk = ~mclk;
	assign dio_in = dio_out & ~dio_oe_n | p_dio;
	assign dav_in = dav_out & ~dav_oe_n | p_dav;
	assign nrfd_in = nrfd_out & ~nrfd_oe_n | p_nrfd;
	assign ndac_in = ndac_out & ~ndac_oe_n | p_ndac;
	assign eoi_in = eoi_out & ~eoi_oe_n | p_eoi;
	gsre_engine #(.TMO_CYC(50)) i_gsre_engine (.*);
	gsre_peer i_gsre_peer (.mclk, .nrst, .talk_en, .stall, .slow, .dio(dio_in), .dav(dav_in), .nrfd(nrfd_in),
		.ndac(ndac_in), .atn(atn_out & ~atn_oe_n), .eoi(eoi_in), .dio_o(p_dio), .dav_o(p_dav), .nrfd_o(p_nrfd),
		.ndac_o(p_ndac), .eoi_o(p_eoi));
	// ========================================
	// tasks
	task summarize;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk(input string what, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e)
		begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask
	task tk(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task go(input logic rx, input int npush);
		int i;
		array_receive_call = rx;
		send_call = !rx;
		tk(1);
		{array_receive_call, send_call} = '0;
		for (i = 0; i < npush; i++)
		begin
			tx_char_in = 8'h41 + i[7:0];
			tx_char_valid = 1;
			chk("tx ready", 1, tx_char_ready);
			tk(1);
		end
		tx_char_valid = 0;
		if (npush > 0)
			chk("tx full", 0, tx_char_ready);
		tx_char_last = !rx;
		for (i = 0; i < 400 && done !== 1'b1; i++)
			tk(1);
		tx_char_last = 0;
		chk("done seen", 1, done);
		if (i == 400)
			summarize();
	endtask
	task q(input logic [8:0] b);
		i_gsre_peer.txq.push_back(b);
		exp_q.push_back({2'b00, b[7:0]});
	endtask
	task rx_run(input logic [7:0] term, input logic [15:0] maxlen, input logic [7:0] st, input int n);
		rcv_term = term;
		rcv_max_len = maxlen;
		talk_en = 1;
		go(1, 0);
		chk("rx status", st, status);
		chk("rx count", n, xfer_count);
		talk_en = 0;
		i_gsre_peer.txq.delete();
		rx_ready = 1;
		for (int i = 0; i < n; i++)
		begin
			chk("rx byte", exp_q[i], rx_data);
			tk(1);
		end
		rx_ready = 0;
		chk("rx empty", 0, rx_valid);
		exp_q.delete();
	endtask
	task t_board;
		chk("board at reset", 0, board_active);
		for (int b = 0; b < 4; b++)
		begin
			board_select_id = b[1:0];
			board_select_strobe = 1;
			tk(1);
			board_select_strobe = 0;
			tk(1);
			chk("board active", b == 2, board_active);
		end
		send_call = 1;
		tk(1);
		send_call = 0;
		tk(1);
		chk("refused", 0, busy);
		board_select_id = 2'h2;
		board_select_strobe = 1;
		tk(1);
		board_select_strobe = 0;
		tk(1);
	endtask
	task t_send;
		trm = '{16'h000A, 16'h0D0A, 16'h000D, 16'h0A0D};
		for (int s = 0; s < 4; s++)
		begin
			slow = s[3:0];
			for (int i = 0; i < 8; i++)
				exp_q.push_back({2'b00, 8'h41 + i[7:0]});
			send_addr = 8'd27 + s[7:0] * 8'd65;
			exp_q.push_front({5'b10001, send_addr[4:0]});
			exp_q.push_front(10'h23F);
			if (trm[s][15:8] != 8'h00)
				exp_q.push_back({2'b00, trm[s][15:8]});
			exp_q.push_back({2'b01, trm[s][7:0]});
			go(0, 8);
			chk("tx count", 8, xfer_count);
			chk("tx status", 0, status);
			chk("tx length", exp_q.size(), i_gsre_peer.rxq.size());
			foreach (exp_q[i])
				chk("tx bus byte", exp_q[i], i_gsre_peer.rxq[i]);
			exp_q.delete();
			i_gsre_peer.rxq.delete();
		end
		cfg_index = 3'h2;
		cfg_len = 2'h2;
		cfg_chars = 16'h3B2C;
		send_terminator_config_call = 1;
		tk(1);
		send_terminator_config_call = 0;
		send_addr = 8'h85;
		exp_q = '{10'h23F, 10'h225, 10'h02C, 10'h13B};
		go(0, 0);
		chk("cfg length", 4, i_gsre_peer.rxq.size());
		foreach (exp_q[i])
			chk("cfg bus byte", exp_q[i], i_gsre_peer.rxq[i]);
		exp_q.delete();
		i_gsre_peer.rxq.delete();
		is_controller = 0;
		send_addr = 8'h05;
		go(0, 0);
		chk("tx status", 8'h02, status);
		is_controller = 1;
		send_addr = 8'h1F;
		go(0, 0);
		chk("tx status", 8'h01, status);
		send_addr = 8'h22;
		go(0, 0);
		chk("tx status", 8'h01, status);
		stall = 1;
		send_addr = 8'h05;
		go(0, 0);
		chk("tx status", 8'h08, status);
		stall = 0;
		i_gsre_peer.rxq.delete();
	endtask
	task t_receive;
		is_listener = 0;
		go(1, 0);
		chk("rx status", 8'h02, status);
		is_listener = 1;
		for (int k = 0; k < 4; k++)
		begin
			q(9'h061);
			q({1'b0, in_term_chars[8*k +: 8]});
			q(9'h062);
			rx_run({6'h01, k[1:0]}, 16'h000A, 8'h20, 2);
		end
		q(9'h061);
		q(9'h03B);
		q(9'h162);
		rx_run(8'h03, 16'h000A, 8'h20, 3);
		repeat (5) q(9'h063);
		rx_run(8'h04, 16'h0003, 8'h00, 3);
		q(9'h064);
		q(9'h065);
		rx_run(8'h00, 16'h000A, 8'h08, 2);
		rx_run(8'h00, 16'h0000, 8'h00, 0);
	endtask
	// ========================================
	// main sequence
	initial
	begin
		{board_select_id, cfg_len, cfg_index, slow, rcv_term, send_addr, tx_char_in, rcv_max_len, cfg_chars} = '0;
		{board_select_strobe, array_receive_call, send_call, tx_char_valid, tx_char_last, rx_ready, stall} = '0;
		{send_terminator_config_call, talk_en} = '0;
		{board_number, is_listener, is_controller} = 4'hF;
		board_number = 2'h2;
		in_term_chars = 32'h3B2C0D0A;
		repeat (5) @(posedge mclk);
		#1;
		nrst = 1;
		tk(1);
		t_board();
		t_send();
		t_receive();
		summarize();
	end
endmodule // tb_top
`default_nettype wire

// >>> verilog/gsre_engine.v
/*
 gpib send/receive engine: array receive into a fifo, addressed send from a
 fifo with selectable terminator sequence, board number selection.
 assumes host strobes on mclk; bus handshake pins are asynchronous and are
 synchronised here; open collector pins are in/out/oe triples except atn (out/oe only), oe low = drive.
*/
// Contract
// RULE_01: receive status: eot bit5, timeout bit3, notlistener bit1
// RULE_02: eot set on eoi or terminator only
// RULE_03: successful receive may report nonzero status
// RULE_04: timeout sets timeout flag in status
// RULE_05: receive unaddressed as listener sets notlistener
// RULE_06: host addresses board to listen first
// RULE_07: send: address listener, become talker, transmit (code sends UNL and listen address, then data; no talk address byte)
// RULE_08: address byte: addr 4:0, bit5 zero, selector 7:6
// RULE_09: selector picks one of four configurable sequences
// RULE_10: adding 64/128/192 selects terminator 1/2/3
// RULE_11: target addresses limited to 0..30
// RULE_12: send status: timeout bit3, notctrl bit1, badaddr bit0
// RULE_13: send while not controller sets notctrl
// RULE_14: board number 0..3 tied to base
// RULE_15: host assigns board numbers before selecting
// RULE_16: term bit2 enables char match, bits1:0 select
// RULE_17: stop on max count, terminator, or eoi
// RULE_18: stalled handshake aborts, count kept
`timescale 1ns/1ps
`default_nettype none
`include "gsre_consts.vh"

module gsre_engine #(
	parameter TMO_CYC = `GSRE_TMO_CYC,
	parameter FIFO_DEPTH = 8,
	parameter FIFO_AW = 3
) (
	// clock and reset
	input wire mclk,
	input wire nrst,
	// board selection
	input wire [1:0] board_number,
	input wire [1:0] board_select_id,
	input wire board_select_strobe,
	output wire board_active,
	// bus role status
	input wire is_listener,
	input wire is_controller,
	// receive command
	input wire array_receive_call,
	input wire [7:0] rcv_term,
	input wire [15:0] rcv_max_len,
	output wire rx_valid,
	input wire rx_ready,
	output wire [7:0] rx_data,
	// send command
	input wire send_call,
	input wire [7:0] send_addr,
	input wire [7:0] tx_char_in,
	input wire tx_char_valid,
	output wire tx_char_ready,
	input wire tx_char_last,
	// terminator configuration
	input wire [31:0] in_term_chars,
	input wire send_terminator_config_call,
	input wire [2:0] cfg_index,
	input wire [1:0] cfg_len,
	input wire [15:0] cfg_chars,
	// completion
	output wire busy,
	output wire done,
	output wire [7:0] status,
	output wire [15:0] xfer_count,
	// gpib data and handshake pins
	input wire [7:0] dio_in,
	output wire [7:0] dio_out,
	output wire [7:0] dio_oe_n,
	input wire dav_in,
	output wire dav_out,
	output wire dav_oe_n,
	input wire nrfd_in,
	output wire nrfd_out,
	output wire nrfd_oe_n,
	input wire ndac_in,
	output wire ndac_out,
	output wire ndac_oe_n,
	input wire eoi_in,
	output wire eoi_out,
	output wire eoi_oe_n,
	output wire atn_out,
	output wire atn_oe_n
);

	localparam S_IDLE = 4'h0;
	localparam S_RX_WAIT = 4'h1;
	localparam S_RX_ACK = 4'h2;
	localparam S_RX_REL = 4'h3;
	localparam S_TX_LOAD = 4'h4;
	localparam S_TX_RDY = 4'h5;
	localparam S_TX_DAV = 4'h6;
	localparam S_TX_ACC = 4'h7;
	localparam S_DONE = 4'h8;

	// ========================================
	// pin synchronisers
	wire [11:0] pins_s;
	gsre_sync #(.W(12)) u_sync (
		.mclk(mclk),
		.nrst(nrst),
		.async_in({eoi_in, ndac_in, nrfd_in, dav_in, dio_in}),
		.sync_out(pins_s)
	);
	wire [7:0] dio_s = pins_s[7:0];
	wire dav_s = pins_s[8];
	wire nrfd_s = pins_s[9];
	wire ndac_s = pins_s[10];
	wire eoi_s = pins_s[11];

	// ========================================
	// registers
	reg [3:0] st_q;
	reg mode_tx_q;
	reg [1:0] board_q;
	reg [7:0] status_q;
	reg done_q;
	reg [15:0] cnt_q;
	reg [15:0] max_q;
	reg [2:0] rterm_q;
	reg [7:0] send_q;
	reg [2:0] phase_q;
	reg [1:0] tidx_q;
	reg [7:0] txb_q;
	reg txeoi_q;
	reg txatn_q;
	reg [31:0] tmo_q;
	reg [1:0] olen_q [0:3];
	reg [15:0] ochr_q [0:3];
	reg [7:0] rxb_q;
	reg rxpush_q;

	wire fifo_in_ready;
	wire fifo_out_valid;
	wire [7:0] fifo_out_data;
	reg fifo_pop;

	// ========================================
	// functions
	function [7:0] term_char;
		input [31:0] chars;
		input [1:0] idx;
		begin
			term_char = chars[idx*8 +: 8];
		end
	endfunction

	function addr_bad;
		input [7:0] a;
		begin
			addr_bad = a[`GSRE_ADR_ZERO_BIT] || (a[4:0] > `GSRE_MAX_ADDR); // RULE_08 RULE_11
		end
	endfunction

	// ========================================
	// board selection
	assign board_active = (board_q == board_number); // RULE_14

	// ========================================
	// fifo in data path
	gsre_fifo #(.W(8), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
		.mclk(mclk),
		.nrst(nrst),
		.flush(mode_tx_q && st_q == S_DONE),
		.in_valid(mode_tx_q ? tx_char_valid && tx_char_ready : rxpush_q),
		.in_ready(fifo_in_ready),
		.in_data(mode_tx_q ? tx_char_in : rxb_q),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_out_data)
	);

	assign tx_char_ready = mode_tx_q && st_q != S_IDLE && st_q != S_DONE && fifo_in_ready;
	assign rx_valid = !mode_tx_q && fifo_out_valid;
	assign rx_data = fifo_out_data;

	wire [7:0] cur_term = term_char(in_term_chars, rterm_q[1:0]);
	wire [1:0] sel = send_q[`GSRE_ADR_SEL_HI:`GSRE_ADR_SEL_LO]; // RULE_09 RULE_10
	wire [15:0] seq_chars = ochr_q[sel];
	wire [1:0] seq_len = olen_q[sel];
	wire tmo_hit = (tmo_q >= TMO_CYC - 1);

	always @*
	begin
		fifo_pop = 1'b0;
		if (!mode_tx_q)
			fifo_pop = rx_ready;
		else if (st_q == S_TX_LOAD && phase_q == 3'h2 && fifo_out_valid)
			fifo_pop = 1'b1;
	end

	// ========================================
	// main sequencer
	integer k;
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			st_q <= S_IDLE;
			mode_tx_q <= 1'b0;
			board_q <= 2'h0;
			status_q <= 8'h00;
			done_q <= 1'b0;
			cnt_q <= 16'h0000;
			max_q <= 16'h0000;
			rterm_q <= 3'h0;
			send_q <= 8'h00;
			phase_q <= 3'h0;
			tidx_q <= 2'h0;
			txb_q <= 8'h00;
			txeoi_q <= 1'b0;
			txatn_q <= 1'b0;
			tmo_q <= 32'h00000000;
			rxb_q <= 8'h00;
			rxpush_q <= 1'b0;
			for (k = 0; k < 4; k = k + 1)
			begin
				olen_q[k] <= 2'h0;
				ochr_q[k] <= 16'h0000;
			end
			olen_q[0] <= 2'h1; // RULE_09
			ochr_q[0] <= {8'h00, `GSRE_CH_LF};
			olen_q[1] <= 2'h2;
			ochr_q[1] <= {`GSRE_CH_LF, `GSRE_CH_CR};
			olen_q[2] <= 2'h1;
			ochr_q[2] <= {8'h00, `GSRE_CH_CR};
			olen_q[3] <= 2'h2;
			ochr_q[3] <= {`GSRE_CH_CR, `GSRE_CH_LF};
		end
		else
		begin
			done_q <= 1'b0;
			rxpush_q <= 1'b0;
			if (board_select_strobe)
				board_q <= board_select_id; // RULE_14
			if (send_terminator_config_call && st_q == S_IDLE)
			begin
				olen_q[cfg_index[1:0]] <= cfg_len; // RULE_09
				ochr_q[cfg_index[1:0]] <= cfg_chars;
			end
			if (st_q == S_IDLE || st_q == S_DONE)
				tmo_q <= 32'h00000000;
			else if (st_q == S_RX_WAIT || st_q == S_RX_REL || st_q == S_TX_RDY || st_q == S_TX_ACC)
				tmo_q <= tmo_q + 1'b1;
			else
				tmo_q <= 32'h00000000;
			case (st_q)
			S_IDLE:
			begin
				if (board_active && array_receive_call)
				begin
					mode_tx_q <= 1'b0;
					cnt_q <= 16'h0000;
					max_q <= rcv_max_len;
					rterm_q <= rcv_term[2:0]; // RULE_16
					if (!is_listener)
					begin
						status_q <= 8'h01 << `GSRE_ST_NLS_BIT; // RULE_05 RULE_01
						st_q <= S_DONE;
					end
					else
					begin
						status_q <= 8'h00;
						st_q <= (rcv_max_len == 16'h0000) ? S_DONE : S_RX_WAIT;
					end
				end
				else if (board_active && send_call)
				begin
					mode_tx_q <= 1'b1;
					cnt_q <= 16'h0000;
					send_q <= send_addr;
					phase_q <= 3'h0;
					tidx_q <= 2'h0;
					status_q <= 8'h00;
					if (!is_controller)
					begin
						status_q <= 8'h01 << `GSRE_ST_NCT_BIT; // RULE_13 RULE_12
						st_q <= S_DONE;
					end
					else if (addr_bad(send_addr))
					begin
						status_q <= 8'h01 << `GSRE_ST_ADR_BIT; // RULE_12
						st_q <= S_DONE;
					end
					else
						st_q <= S_TX_LOAD;
				end
			end
			S_RX_WAIT:
			begin
				if (tmo_hit)
				begin
					status_q <= 8'h01 << `GSRE_ST_TMO_BIT; // RULE_18 RULE_04
					st_q <= S_DONE;
				end
				else if (dav_s && fifo_in_ready)
				begin
					rxb_q <= dio_s;
					st_q <= S_RX_ACK;
				end
			end
			S_RX_ACK:
			begin
				cnt_q <= cnt_q + 1'b1;
				rxpush_q <= 1'b1;
				if (eoi_s || (rterm_q[`GSRE_TRM_ENA_BIT] && rxb_q == cur_term))
					status_q <= 8'h01 << `GSRE_ST_EOT_BIT; // RULE_02 RULE_03 RULE_17
				else if (cnt_q + 1'b1 == max_q)
					status_q <= 8'h00; // RULE_02 RULE_17
				st_q <= S_RX_REL;
			end
			S_RX_REL:
			begin
				if (tmo_hit)
				begin
					status_q <= 8'h01 << `GSRE_ST_TMO_BIT; // RULE_04
					st_q <= S_DONE;
				end
				else if (!dav_s)
					st_q <= (status_q[`GSRE_ST_EOT_BIT] || cnt_q == max_q) ? S_DONE : S_RX_WAIT; // RULE_17
			end
			S_TX_LOAD:
			begin
				st_q <= S_TX_RDY;
				txeoi_q <= 1'b0;
				txatn_q <= 1'b0;
				case (phase_q)
				3'h0:
				begin
					txb_q <= `GSRE_CMD_UNL; // RULE_07
					txatn_q <= 1'b1;
				end
				3'h1:
				begin
					txb_q <= `GSRE_CMD_LAG | {3'h0, send_q[4:0]}; // RULE_07 RULE_08
					txatn_q <= 1'b1;
				end
				3'h2:
				begin
					if (fifo_out_valid)
						txb_q <= fifo_out_data; // RULE_07
					else if (tx_char_last && !tx_char_valid)
					begin
						phase_q <= 3'h3;
						tidx_q <= 2'h0;
						st_q <= S_TX_LOAD;
					end
					else
						st_q <= S_TX_LOAD;
				end
				default:
				begin
					if (tidx_q >= seq_len)
						st_q <= S_DONE;
					else
					begin
						txb_q <= seq_chars[tidx_q[0]*8 +: 8]; // RULE_09
						txeoi_q <= (tidx_q + 1'b1 == seq_len);
					end
				end
				endcase
			end
			S_TX_RDY:
			begin
				if (tmo_hit)
				begin
					status_q <= 8'h01 << `GSRE_ST_TMO_BIT; // RULE_18 RULE_04
					st_q <= S_DONE;
				end
				else if (!nrfd_s)
					st_q <= S_TX_DAV;
			end
			S_TX_DAV:
				st_q <= S_TX_ACC;
			S_TX_ACC:
			begin
				if (tmo_hit)
				begin
					status_q <= 8'h01 << `GSRE_ST_TMO_BIT; // RULE_18 RULE_04
					st_q <= S_DONE;
				end
				else if (!ndac_s)
				begin
					st_q <= S_TX_LOAD;
					if (phase_q < 3'h2)
						phase_q <= phase_q + 1'b1;
					else if (phase_q == 3'h2)
						cnt_q <= cnt_q + 1'b1;
					else
						tidx_q <= tidx_q + 1'b1;
				end
			end
			S_DONE:
			begin
				done_q <= 1'b1;
				st_q <= S_IDLE;
			end
			default:
				st_q <= S_IDLE;
			endcase
		end
	end

	// ========================================
	// outputs
	wire rx_act = !mode_tx_q && (st_q == S_RX_WAIT || st_q == S_RX_ACK || st_q == S_RX_REL);
	wire tx_act = mode_tx_q && (st_q == S_TX_RDY || st_q == S_TX_DAV || st_q == S_TX_ACC);
	assign busy = (st_q != S_IDLE);
	assign done = done_q;
	assign status = status_q;
	assign xfer_count = cnt_q; // RULE_18
	assign dio_out = txb_q;
	assign dio_oe_n = tx_act ? 8'h00 : 8'hFF;
	assign dav_out = (st_q == S_TX_ACC);
	assign dav_oe_n = !tx_act;
	assign eoi_out = txeoi_q;
	assign eoi_oe_n = !tx_act;
	assign atn_out = txatn_q && tx_act;
	assign atn_oe_n = !(mode_tx_q && busy);
	assign nrfd_out = !(st_q == S_RX_WAIT && fifo_in_ready);
	assign nrfd_oe_n = !rx_act;
	assign ndac_out = !(st_q == S_RX_REL);
	assign ndac_oe_n = !rx_act;

endmodule // gsre_engine

`default_nettype wire

// >>> verilog/gsre_fifo.v
/*
 flip-flop fifo with valid/ready on both sides.
 assumes a single clock mclk and active low asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none

module gsre_fifo #(
	parameter W = 8,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	// clock and reset
	input wire mclk,
	input wire nrst,
	input wire flush,
	// write side
	input wire in_valid,
	output wire in_ready,
	input wire [W-1:0] in_data,
	// read side
	output wire out_valid,
	input wire out_ready,
	output wire [W-1:0] out_data
);

	reg [W-1:0] mem_q [0:DEPTH-1];
	reg [AW-1:0] wp_q;
	reg [AW-1:0] rp_q;
	reg [AW:0] cnt_q;
	wire push;
	wire pop;
	integer i;

	assign in_ready = (cnt_q != DEPTH[AW:0]);
	assign out_valid = (cnt_q != {(AW+1){1'b0}});
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem_q[rp_q];

	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			wp_q <= {AW{1'b0}};
			rp_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
			for (i = 0; i < DEPTH; i = i + 1)
				mem_q[i] <= {W{1'b0}};
		end
		else if (flush)
		begin
			wp_q <= {AW{1'b0}};
			rp_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
			begin
				mem_q[wp_q] <= in_data;
				wp_q <= (wp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_q + 1'b1;
			end
			if (pop)
				rp_q <= (rp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_q + 1'b1;
			if (push && !pop)
				cnt_q <= cnt_q + 1'b1;
			else if (pop && !push)
				cnt_q <= cnt_q - 1'b1;
		end
	end

endmodule // gsre_fifo

`default_nettype wire

// >>> verilog/gsre_sync.v
/*
 two flip-flop synchroniser for a vector of pin inputs.
 assumes a single clock mclk and active low asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none

module gsre_sync #(
	parameter W = 1
) (
	// clock and reset
	input wire mclk,
	input wire nrst,
	// data
	input wire [W-1:0] async_in,
	output wire [W-1:0] sync_out
);

	reg [W-1:0] meta_q;
	reg [W-1:0] sync_q;

	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			meta_q <= {W{1'b0}};
			sync_q <= {W{1'b0}};
		end
		else
		begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;

endmodule // gsre_sync

`default_nettype wire
